//--- testbench/dsr_sync_src.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_sync_src (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Requested pin levels, d..a
	input wire logic [3:0] level_req,
	// Sync pins
	output logic sync_input_a,
	output logic sync_input_b,
	output logic sync_input_c,
	output logic sync_input_d
);
	// Pins idle low; they move only after an edge, like a registered driver
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			{sync_input_d, sync_input_c, sync_input_b, sync_input_a} <= 4'h0;
		end else begin
			{sync_input_d, sync_input_c, sync_input_b, sync_input_a} <= level_req;
		end
	end
endmodule // dsr_sync_src
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dsr_pkg::*;
	typedef struct packed {
		logic [3:0] pins;
		logic [15:0] fm;
		logic [15:0] tg;
		logic [15:0] osc;
		logic [11:0] exp;
	} dsr_row_t;
	localparam logic [54:0] PA = 55'h6A_BCDE_F012_3456;
	localparam logic [54:0] PB = 55'h35_1122_3344_5566;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [6:0] avs_address = 7'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] pin_lvl = 4'h0;
	logic sync_input_a, sync_input_b, sync_input_c, sync_input_d;
	dsr_power_t pwr_in = '0;
	logic pwr_valid = 1'b0;
	logic [15:0] self_test_sum = 16'hC35A;
	dsr_sync_t sync_out;
	logic agc_freeze;
	int num_errors = 0;
	int n_tests = 0;
	int cnt;
	dsr_row_t rows [22];
	logic [15:0] pexp [8];
	logic [15:0] w;

	always #10 clk_sys = ~clk_sys;

	dsr_sync_src u_src (.clk_sys(clk_sys), .rst(rst), .level_req(pin_lvl),
		.sync_input_a(sync_input_a), .sync_input_b(sync_input_b),
		.sync_input_c(sync_input_c), .sync_input_d(sync_input_d));

	dsr_sync_power dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .sync_input_a(sync_input_a),
		.sync_input_b(sync_input_b), .sync_input_c(sync_input_c),
		.sync_input_d(sync_input_d), .pwr_in(pwr_in), .pwr_valid(pwr_valid),
		.self_test_sum(self_test_sum), .sync_out(sync_out), .agc_freeze(agc_freeze));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until waitrequest is sampled low; one idle edge after it
	task automatic bus(input logic wr, input logic [4:0] idx, input logic [15:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {16'h0000, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) num_errors++;
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [4:0] idx, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rdc(input string what, input logic [4:0] idx, input logic [15:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 16'h0000, q);
		check(what, q, {16'h0000, exp});
	endtask

	task automatic wr_sel(input logic [15:0] fm, input logic [15:0] tg, input logic [15:0] osc);
		wr(IDX_SYNC_FM, fm);
		wr(IDX_SYNC_TG, tg);
		wr(IDX_SYNC_OSC, osc);
	endtask

	// Counts sampled edges with every selected sync high
	task automatic count_all(input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge clk_sys);
			if (sync_out === 12'hFFF) c++;
		end
	endtask

	task automatic report_and_stop;
		$display("Checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Whole run is under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		report_and_stop();
	end

	initial begin
		for (int c = 0; c < 4; c++) begin
			w = 16'h1111 * c[15:0];
			rows[2*c] = {4'h1 << c, w, w, w, 12'hFFF};
			rows[2*c+1] = {~(4'h1 << c), w, w, w, 12'h000};
		end
		rows[8] = {4'hF, 16'h6666, 16'h6666, 16'h6666, 12'h000};
		rows[9] = {4'h0, 16'hFFFF, 16'hFFFF, 16'hFFFF, 12'hFFF};
		// One function at constant high, the rest at constant low
		for (int i = 0; i < 12; i++) begin
			w = 16'h6666 | (16'h1000 >> (4 * (i % 4)));
			rows[10+i] = {4'h0, (i / 4 == 0) ? w : 16'h6666, (i / 4 == 1) ? w : 16'h6666,
				(i / 4 == 2) ? w : 16'h6666, 12'h001 << i};
		end
		pexp[1] = PA[15:0];
		pexp[2] = PA[31:16];
		pexp[3] = PA[47:32];
		pexp[4] = PB[15:0];
		pexp[5] = PB[31:16];
		pexp[6] = PB[47:32];
		pexp[7] = {PA[54:48], 1'b0, PB[54:48], 1'b0};
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rdc("sync_fm_rst", IDX_SYNC_FM, RST_SYNC_FM);
		rdc("sync_tg_rst", IDX_SYNC_TG, RST_SYNC_TG);
		rdc("sync_osc_rst", IDX_SYNC_OSC, RST_SYNC_OSC);
		for (int i = 1; i < 8; i++) begin
			rdc("result_rst", 5'(i), RST_RESULT);
		end
		check("freeze_rst", {31'h0, agc_freeze}, 32'h0);
		rdc("checksum", IDX_CHECKSUM, 16'hC35A);
		wr(IDX_CHECKSUM, 16'hFFFF);
		rdc("checksum_ro", IDX_CHECKSUM, 16'hC35A);
		wr(5'h10, 16'hFFFF);
		rdc("unmapped", 5'h10, 16'h0000);
		foreach (rows[i]) begin
			pin_lvl <= rows[i].pins;
			wr_sel(rows[i].fm, rows[i].tg, rows[i].osc);
			repeat (8) @(posedge clk_sys);
			check("sync_out", {20'h0, sync_out}, {20'h0, rows[i].exp});
			check("agc_freeze", {31'h0, agc_freeze}, {31'h0, rows[i].exp[2]});
			rdc("sync_word", IDX_SYNC_OSC, rows[i].osc & SEL_WMASK);
		end
		// Host bit alone freezes while the selector sits at constant low
		wr_sel(RST_SYNC_FM, 16'h0000, 16'h0000);
		wr(IDX_CTRL, 16'h0002);
		repeat (4) @(posedge clk_sys);
		check("host_freeze", {31'h0, agc_freeze}, 32'h1);
		check("freeze_sync", {20'h0, sync_out}, 32'h0);
		wr(IDX_CTRL, 16'h0000);
		repeat (4) @(posedge clk_sys);
		check("freeze_off", {31'h0, agc_freeze}, 32'h0);
		wr_sel(16'h5555, 16'h5555, 16'h5555);
		wr(IDX_CTRL, 16'h0001);
		count_all(10, cnt);
		check("oneshot", 32'(cnt), 32'd1);
		// Let the reset-time count run out before measuring the short period
		wr_sel(16'h4444, 16'h4444, 16'h4444);
		wr(IDX_CNT_PERIOD, 16'h0003);
		repeat (260) @(posedge clk_sys);
		count_all(40, cnt);
		check("counter", 32'(cnt), 32'd10);
		pwr_in <= {PA, PB};
		pwr_valid <= 1'b1;
		@(posedge clk_sys);
		pwr_valid <= 1'b0;
		pwr_in <= '1;
		@(posedge clk_sys);
		wr(IDX_PAB_TOP, 16'hFFFF);
		wr(IDX_PA_MID, 16'hFFFF);
		for (int i = 1; i < 8; i++) begin
			rdc("result", 5'(i), pexp[i]);
		end
		rdc("period", IDX_CNT_PERIOD, 16'h0003);
		// Checksum register tracks its input one edge behind
		self_test_sum <= 16'h5AC3;
		@(posedge clk_sys);
		rdc("checksum_new", IDX_CHECKSUM, 16'h5AC3);
		// Upper lane alone; the lower fields must keep their codes
		avs_byteenable <= 4'h2;
		wr(IDX_SYNC_TG, 16'h7777);
		avs_byteenable <= 4'hF;
		rdc("byte_lane", IDX_SYNC_TG, 16'h7744);
		// Mid-run reset must restore selectors, freeze and results
		wr(IDX_CTRL, 16'h0002);
		wr(IDX_SYNC_FM, 16'h7777);
		check("freeze_pre_rst", {31'h0, agc_freeze}, 32'h1);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check("freeze_mid_rst", {31'h0, agc_freeze}, 32'h0);
		rdc("sync_fm_mid_rst", IDX_SYNC_FM, RST_SYNC_FM);
		rdc("result_mid_rst", IDX_PA_MID, RST_RESULT);
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire

//--- verilog/dsr_pkg.sv
`default_nettype none
package dsr_pkg;
	// Register indices; byte address is four times the index
	localparam logic [4:0] IDX_CHECKSUM = 5'h00;
	localparam logic [4:0] IDX_PA_LOW = 5'h01;
	localparam logic [4:0] IDX_PA_MID = 5'h02;
	localparam logic [4:0] IDX_PA_UMID = 5'h03;
	localparam logic [4:0] IDX_PB_LOW = 5'h04;
	localparam logic [4:0] IDX_PB_MID = 5'h05;
	localparam logic [4:0] IDX_PB_UMID = 5'h06;
	localparam logic [4:0] IDX_PAB_TOP = 5'h07;
	localparam logic [4:0] IDX_SYNC_FM = 5'h1B;
	localparam logic [4:0] IDX_SYNC_TG = 5'h1C;
	localparam logic [4:0] IDX_SYNC_OSC = 5'h1D;
	localparam logic [4:0] IDX_CNT_PERIOD = 5'h1E;
	localparam logic [4:0] IDX_CTRL = 5'h1F;

	// Sync select field layout: four 3-bit fields per word
	localparam int SEL_W = 3;
	localparam int SEL_PITCH = 4;
	localparam int SEL_TOP_POS = 12;
	localparam int NUM_SEL = 12;
	localparam logic [15:0] SEL_WMASK = 16'h7777;

	// Reset values
	localparam logic [15:0] RST_SYNC_FM = 16'h0060;
	localparam logic [15:0] RST_SYNC_TG = 16'h0000;
	localparam logic [15:0] RST_SYNC_OSC = 16'h0000;
	localparam logic [15:0] RST_CNT_PERIOD = 16'h00FF;
	localparam logic [15:0] RST_RESULT = 16'h0000;

	// Control word bits
	localparam int CTRL_ONESHOT_BIT = 0;
	localparam int CTRL_FREEZE_BIT = 1;

	// Power result geometry
	localparam int PWR_W = 55;
	localparam int TOP_A_POS = 9;
	localparam int TOP_B_POS = 1;

	// Sync source codes
	typedef enum logic [2:0] {
		SRC_EXT_A = 3'h0,
		SRC_EXT_B = 3'h1,
		SRC_EXT_C = 3'h2,
		SRC_EXT_D = 3'h3,
		SRC_COUNTER = 3'h4,
		SRC_ONESHOT = 3'h5,
		SRC_LOW = 3'h6,
		SRC_HIGH = 3'h7
	} dsr_src_t;

	// Selected sync per channel function, index 11 down to 0
	typedef struct packed {
		logic phase_load;
		logic freq_load;
		logic dither_reset;
		logic nco_reset;
		logic agc_init;
		logic gain_load;
		logic tadj_reg;
		logic tadj_fine;
		logic serial;
		logic agc_freeze;
		logic pmeter;
		logic cic;
	} dsr_sync_t;

	typedef struct packed {
		logic [PWR_W-1:0] a;
		logic [PWR_W-1:0] b;
	} dsr_power_t;
endpackage
`default_nettype wire

//--- verilog/dsr_sync_power.sv
// Function
// - Sync code 0-3 external A-D, 4 counter, 5 write one-shot, 6 low, 7 high
// - CIC selector picks the sync fixing the decimation instant
// - Power meter selector picks the sync timing power measurement
// - Freeze selector picks a sync whose level holds AGC frozen
// - Freeze selector resets to constant low; host bit alone governs freeze
// - Serial selector picks the sync aligning serial output state machines
// - Fine time-adjust selector picks the zero-insertion sync
// - Time-adjust register selector picks when new adjust values apply
// - Gain selector picks when the AGC gain value is applied
// - AGC init selector picks the sync initialising the AGC
// - NCO reset selector picks the sync clearing the phase accumulator
// - Dither selector picks the sync resetting the phase dither generator
// - Frequency selector picks when a new NCO frequency loads
// - Phase selector picks when a new NCO phase offset loads
// - Sixteen-bit checksum register shows the self-test result
// - A middle word returns measurement bits 31 to 16
// - A result is 55 bits; top seven in bits 15-9, bit 8 unused
// - B result is 55 bits; top seven in bits 7-1, bit 0 unused
// - B low word returns bits 15 to 0
// - B middle word returns bits 31 to 16
// - B upper-middle word returns bits 47 to 32
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dsr_sync_power (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// External sync pins
	input wire logic sync_input_a,
	input wire logic sync_input_b,
	input wire logic sync_input_c,
	input wire logic sync_input_d,
	// Measurement and self test
	input wire dsr_pkg::dsr_power_t pwr_in,
	input wire logic pwr_valid,
	input wire logic [15:0] self_test_sum,
	// Selected syncs to channel functions
	output dsr_pkg::dsr_sync_t sync_out,
	output logic agc_freeze
);
	import dsr_pkg::*;

	logic ack_q;
	logic req;
	logic acc;
	logic wr_acc;
	logic [4:0] idx;
	logic [15:0] wmask;
	logic [15:0] wdata;
	logic [15:0] sync_fm_q;
	logic [15:0] sync_tg_q;
	logic [15:0] sync_osc_q;
	logic [15:0] period_q;
	logic [15:0] cnt_q;
	logic cnt_pulse_q;
	logic oneshot_q;
	logic host_freeze_q;
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] filt_q;
	logic [3:0] ext_in;
	logic [47:0] sel_all;
	logic [NUM_SEL-1:0] sync_d;
	logic [NUM_SEL-1:0] sync_q;
	dsr_power_t res_q;
	logic [15:0] chk_q;
	logic [15:0] rd_word;
	logic [31:0] readdata_q;

	// Bus handshake: one wait cycle, answer at the second edge
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign acc = req & ack_q;
	assign wr_acc = avs_write & ack_q;
	assign idx = avs_address[6:2];
	assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wdata = avs_writedata[15:0];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Sync select registers; unused bits always read zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync_fm_q <= RST_SYNC_FM;
			sync_tg_q <= RST_SYNC_TG;
			sync_osc_q <= RST_SYNC_OSC;
		end else if (wr_acc) begin
			if (idx == IDX_SYNC_FM) begin
				sync_fm_q <= (sync_fm_q & ~(wmask & SEL_WMASK)) | (wdata & wmask & SEL_WMASK);
			end
			if (idx == IDX_SYNC_TG) begin
				sync_tg_q <= (sync_tg_q & ~(wmask & SEL_WMASK)) | (wdata & wmask & SEL_WMASK);
			end
			if (idx == IDX_SYNC_OSC) begin
				sync_osc_q <= (sync_osc_q & ~(wmask & SEL_WMASK)) | (wdata & wmask & SEL_WMASK);
			end
		end
	end

	// Counter period and control word
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			period_q <= RST_CNT_PERIOD;
			host_freeze_q <= 1'b0;
		end else if (wr_acc) begin
			if (idx == IDX_CNT_PERIOD) begin
				period_q <= (period_q & ~wmask) | (wdata & wmask);
			end
			if (idx == IDX_CTRL && avs_byteenable[0]) begin
				host_freeze_q <= wdata[CTRL_FREEZE_BIT];
			end
		end
	end

	// One-shot: a single cycle per accepted write of the fire bit
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			oneshot_q <= 1'b0;
		end else begin
			oneshot_q <= wr_acc && idx == IDX_CTRL && avs_byteenable[0]
				&& wdata[CTRL_ONESHOT_BIT];
		end
	end

	// Channel sync counter; period of period_q + 1 cycles
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_q <= RST_CNT_PERIOD;
			cnt_pulse_q <= 1'b0;
		end else begin
			cnt_pulse_q <= (cnt_q == 16'h0000);
			if (cnt_q == 16'h0000) begin
				cnt_q <= period_q;
			end else begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end

	// Pin syncs: three stages, take a change once stages two and three agree
	assign ext_in = {sync_input_d, sync_input_c, sync_input_b, sync_input_a};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
			filt_q <= 4'h0;
		end else begin
			s1_q <= ext_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int k = 0; k < 4; k++) begin
				if (s2_q[k] == s3_q[k]) begin
					filt_q[k] <= s3_q[k];
				end
			end
		end
	end

	// Selector order: cic, pmeter, freeze, serial, tadj_fine, tadj_reg,
	// gain, agc_init, nco, dither, freq, phase
	assign sel_all = {
		sync_osc_q[2:0], 1'b0, sync_osc_q[6:4], 1'b0,
		sync_osc_q[10:8], 1'b0, sync_osc_q[14:12], 1'b0,
		sync_tg_q[2:0], 1'b0, sync_tg_q[6:4], 1'b0,
		sync_tg_q[10:8], 1'b0, sync_tg_q[14:12], 1'b0,
		sync_fm_q[2:0], 1'b0, sync_fm_q[6:4], 1'b0,
		sync_fm_q[10:8], 1'b0, sync_fm_q[14:12], 1'b0
	};

	// Same decode for every function; only the field differs
	for (genvar i = 0; i < NUM_SEL; i++) begin : g_sel
		dsr_src_t code;
		assign code = dsr_src_t'(sel_all[SEL_PITCH*i+SEL_PITCH-1 -: SEL_W]);
		always_comb begin
			unique case (code)
				SRC_EXT_A: sync_d[i] = filt_q[0];
				SRC_EXT_B: sync_d[i] = filt_q[1];
				SRC_EXT_C: sync_d[i] = filt_q[2];
				SRC_EXT_D: sync_d[i] = filt_q[3];
				SRC_COUNTER: sync_d[i] = cnt_pulse_q;
				SRC_ONESHOT: sync_d[i] = oneshot_q;
				SRC_LOW: sync_d[i] = 1'b0;
				SRC_HIGH: sync_d[i] = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync_q <= '0;
			agc_freeze <= 1'b0;
		end else begin
			sync_q <= sync_d;
			// Host bit always works; a selected sync can only add freezing
			agc_freeze <= host_freeze_q | sync_d[2];
		end
	end

	assign sync_out = dsr_sync_t'(sync_q);

	// Results captured as one unit; all power words change together on pwr_valid, the checksum copies its input every edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			res_q <= '0;
			chk_q <= RST_RESULT;
		end else begin
			chk_q <= self_test_sum;
			if (pwr_valid) begin
				res_q <= pwr_in;
			end
		end
	end

	// Read map; results are read-only, writes to them fall away
	always_comb begin
		rd_word = 16'h0000;
		unique case (idx)
			IDX_CHECKSUM: rd_word = chk_q;
			IDX_PA_LOW: rd_word = res_q.a[15:0];
			IDX_PA_MID: rd_word = res_q.a[31:16];
			IDX_PA_UMID: rd_word = res_q.a[47:32];
			IDX_PB_LOW: rd_word = res_q.b[15:0];
			IDX_PB_MID: rd_word = res_q.b[31:16];
			IDX_PB_UMID: rd_word = res_q.b[47:32];
			IDX_PAB_TOP: rd_word = {res_q.a[54:48], 1'b0, res_q.b[54:48], 1'b0};
			IDX_SYNC_FM: rd_word = sync_fm_q;
			IDX_SYNC_TG: rd_word = sync_tg_q;
			IDX_SYNC_OSC: rd_word = sync_osc_q;
			IDX_CNT_PERIOD: rd_word = period_q;
			IDX_CTRL: rd_word = {14'h0000, host_freeze_q, 1'b0};
			default: rd_word = 16'h0000;
		endcase
	end

	// Data latched on the wait cycle, stands while waitrequest is low
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			readdata_q <= 32'h0000_0000;
		end else if (avs_read & ~ack_q) begin
			readdata_q <= {16'h0000, rd_word};
		end
	end

	assign avs_readdata = readdata_q;

	a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (rst)
		(req && !ack_q) |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
		else $error("bus answer not after one wait cycle");

	a_oneshot_single: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_acc && idx == IDX_CTRL && avs_byteenable[0] && wdata[CTRL_ONESHOT_BIT])
		|=> oneshot_q ##1 !oneshot_q)
		else $error("one-shot not a single cycle pulse");

	a_const_levels: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_fm_q[14:12] == 3'h6 && sync_osc_q[2:0] == 3'h7)
		|=> (!sync_q[0] && sync_q[11]))
		else $error("constant sources not honoured");

	a_cic_follows_pin: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_fm_q[14:12] == 3'h0) |=> (sync_out.cic == $past(filt_q[0])))
		else $error("cic sync does not follow input a");

	a_pmeter_counter: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_fm_q[10:8] == 3'h4) |=> (sync_out.pmeter == $past(cnt_pulse_q)))
		else $error("power meter sync does not follow counter");

	a_freeze_level: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_fm_q[6:4] == 3'h3 && !host_freeze_q && filt_q[3]) |=> agc_freeze)
		else $error("freeze not held by selected input");

	a_freeze_default: assert property (@(posedge clk_sys)
		$fell(rst) |-> (sync_fm_q[6:4] == 3'h6 && !agc_freeze))
		else $error("freeze selector not constant low after reset");

	a_nco_oneshot: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_osc_q[14:12] == 3'h5) |=> (sync_out.nco_reset == $past(oneshot_q)))
		else $error("nco reset does not follow one-shot");

	a_result_atomic: assert property (@(posedge clk_sys) disable iff (rst)
		pwr_valid |=> (res_q == $past(pwr_in)))
		else $error("result words not captured together");

	a_result_ro: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_acc && idx >= IDX_PA_LOW && idx <= IDX_PAB_TOP && !pwr_valid) |=> $stable(res_q))
		else $error("result changed by a write");

	a_top_word: assert property (@(posedge clk_sys) disable iff (rst)
		(acc && avs_read && idx == IDX_PAB_TOP && $stable(res_q))
		|-> (avs_readdata[15:0] == {res_q.a[54:48], 1'b0, res_q.b[54:48], 1'b0}))
		else $error("top word packing wrong");

	a_b_mid_word: assert property (@(posedge clk_sys) disable iff (rst)
		(acc && avs_read && idx == IDX_PB_MID && $stable(res_q))
		|-> (avs_readdata == {16'h0000, res_q.b[31:16]}))
		else $error("b middle word wrong");

	a_serial_pin_b: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_fm_q[2:0] == 3'h1) |=> (sync_out.serial == $past(filt_q[1])))
		else $error("serial sync does not follow input b");

	a_tadj_fine_pin: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_tg_q[14:12] == 3'h2) |=> (sync_out.tadj_fine == $past(filt_q[2])))
		else $error("fine adjust sync does not follow input c");

	a_tadj_reg_counter: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_tg_q[10:8] == 3'h4) |=> (sync_out.tadj_reg == $past(cnt_pulse_q)))
		else $error("adjust register sync does not follow counter");

	a_gain_oneshot: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_tg_q[6:4] == 3'h5) |=> (sync_out.gain_load == $past(oneshot_q)))
		else $error("gain sync does not follow one-shot");

	a_agc_init_high: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_tg_q[2:0] == 3'h7) |=> sync_out.agc_init)
		else $error("agc init sync not held high");

	a_dither_pin_d: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_osc_q[10:8] == 3'h3) |=> (sync_out.dither_reset == $past(filt_q[3])))
		else $error("dither sync does not follow input d");

	a_freq_low: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_osc_q[6:4] == 3'h6) |=> !sync_out.freq_load)
		else $error("frequency sync not held low");

	a_phase_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
		(sync_osc_q[2:0] == 3'h0) |=> (sync_out.phase_load == $past(filt_q[0])))
		else $error("phase sync does not follow input a");

	a_checksum_copy: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> (chk_q == $past(self_test_sum)))
		else $error("checksum register does not track its input");

	a_pa_mid_word: assert property (@(posedge clk_sys) disable iff (rst)
		(acc && avs_read && idx == IDX_PA_MID && $stable(res_q))
		|-> (avs_readdata == {16'h0000, res_q.a[31:16]}))
		else $error("a middle word wrong");

	a_pb_low_word: assert property (@(posedge clk_sys) disable iff (rst)
		(acc && avs_read && idx == IDX_PB_LOW && $stable(res_q))
		|-> (avs_readdata == {16'h0000, res_q.b[15:0]}))
		else $error("b low word wrong");

	a_pb_umid_word: assert property (@(posedge clk_sys) disable iff (rst)
		(acc && avs_read && idx == IDX_PB_UMID && $stable(res_q))
		|-> (avs_readdata == {16'h0000, res_q.b[47:32]}))
		else $error("b upper middle word wrong");

	a_pin_filter_agree: assert property (@(posedge clk_sys) disable iff (rst)
		(s2_q == s3_q) |=> (filt_q == $past(s3_q)))
		else $error("pin filter did not take an agreed level");

	a_sel_unused_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(((sync_fm_q | sync_tg_q | sync_osc_q) & ~SEL_WMASK) == 16'h0000))
		else $error("unused selector bits not zero");

	c_write_oneshot: cover property (@(posedge clk_sys) disable iff (rst)
		oneshot_q ##1 sync_out.nco_reset);
	c_freeze_by_pin: cover property (@(posedge clk_sys) disable iff (rst)
		!host_freeze_q && agc_freeze);
	c_read_result: cover property (@(posedge clk_sys) disable iff (rst)
		acc && avs_read && idx == IDX_PAB_TOP);
	c_counter_pulse: cover property (@(posedge clk_sys) disable iff (rst)
		sync_out.pmeter ##1 !sync_out.pmeter);
	c_byte_lane: cover property (@(posedge clk_sys) disable iff (rst)
		wr_acc && avs_byteenable[1:0] == 2'b10);
endmodule // dsr_sync_power
`default_nettype wire
